// ### src/sbcspi_defs.vh
/*
 * Constants of the serial control port frame checker: frame length, clock
 * counter width, command word field positions and mode codes.
 * Assumes it is included by bare name from the design files.
 */
`ifndef SBCSPI_DEFS_VH
`define SBCSPI_DEFS_VH

// -----------------------------------------------------------------------
// Frame format
// -----------------------------------------------------------------------
`define SBCSPI_FRAME_BITS   5'd16
`define SBCSPI_CNT_W        5
`define SBCSPI_WRITE_BIT    7
`define SBCSPI_ADDR_MSB     6
`define SBCSPI_DATA_LSB     8

// -----------------------------------------------------------------------
// Register addresses touched by the command checker
// -----------------------------------------------------------------------
`define SBCSPI_ADDR_MODE    7'h01
`define SBCSPI_ADDR_WDOG    7'h03
`define SBCSPI_ADDR_BUSWK   7'h04
`define SBCSPI_ADDR_WKSRC   7'h06
`define SBCSPI_ADDR_TIMER   7'h0c
`define SBCSPI_ADDR_SUPCTL  7'h0a
`define SBCSPI_ADDR_DEVSTAT 7'h43
`define SBCSPI_ADDR_STAT_LO 7'h40
`define SBCSPI_ADDR_STAT_HI 7'h7e
`define SBCSPI_ADDR_CTL_HI  7'h1e

// -----------------------------------------------------------------------
// Field positions inside the data byte
// -----------------------------------------------------------------------
`define SBCSPI_MODE_MSB     7
`define SBCSPI_MODE_LSB     6
`define SBCSPI_SOFTRST_BIT  5
`define SBCSPI_FAULT_BIT    4
`define SBCSPI_LOADSHARE    3
`define SBCSPI_MEAS_BIT     5
`define SBCSPI_WK1_BIT      0
`define SBCSPI_WK2_BIT      1
`define SBCSPI_TIMER_BIT    2

// -----------------------------------------------------------------------
// Mode codes
// -----------------------------------------------------------------------
`define SBCSPI_MODE_NORMAL  2'h0
`define SBCSPI_MODE_SLEEP   2'h1
`define SBCSPI_MODE_STOP    2'h2
`define SBCSPI_MODE_RESET   2'h3

// -----------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------
`define SBCSPI_RST_BYTE     8'h00

`endif

// ### src/sbcspi_sync.v
/*
 * Two-flip-flop synchroniser for a group of asynchronous pin levels.
 * Assumes the inputs are levels from outside the mclk_i domain.
 */
`timescale 1ns/100ps

module sbcspi_sync #(
   parameter W = 4
) (
   // Clock and reset.
   input  wire         mclk_i,
   input  wire         rst_n_i,
   // Raw and synchronised levels.
   input  wire [W-1:0] async_i,
   input  wire [W-1:0] rst_val_i,
   output reg  [W-1:0] sync_o
);

   reg [W-1:0] meta;   // First stage, read only by the second stage.

   // ---------------------------------------------------------------------
   // Synchroniser stages
   // ---------------------------------------------------------------------
   // The reset value is a constant tied at the instance.
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         meta   <= rst_val_i;
         sync_o <= rst_val_i;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end

endmodule

// ### src/sbcspi_frame_checker.v
/*
 * Slave side of the 16-bit serial control port with frame and command
 * checking. Holds the shift registers, the clock counter, the error flag,
 * the sticky command-fault flag and the mode state it needs to judge
 * commands. Assumes the host is an SPI master on asynchronous pins and
 * that the pad ring resolves serial output from data and enable.
 */
//
// Behaviour
// - Sample input bit on falling clock edge
// - Shift output bit after rising clock edge
// - Select low frames; interpret after select high
// - Release serial output when select goes high
// - Bad command ignored, sticky fault until cleared
// - Stop to Sleep: fault, enter Restart
// - Stop/Sleep from Init: fault, enter Normal
// - Watchdog write odd parity: fault, discard
// - Stop mode accepts only few commands
// - Stop with wake status pending: pulse interrupt
// - Stop to Normal with extras: fault, mode only
// - Sleep with no wake sources: fault, Restart
// - Lone timer wake off: Restart at once
// - Stop with no wake sources is fine
// - Load-share bit cannot be cleared once set
// - Sleep with measured wake pins only: fault
// - Timer on-time not below period: fault
// - All zeros or ones word: fault
// - Unused addresses set fault only in the all-ones word
// - Bad clock count or edges: error next
// - Frames near reset low: error; output high
`timescale 1ns/100ps
`include "sbcspi_defs.vh"

module sbcspi_frame_checker (
   // Clock and reset.
   input  wire       mclk_i,
   input  wire       rst_n_i,
   // Serial pins from the host.
   input  wire       csn_i,
   input  wire       sclk_i,
   input  wire       sdi_i,
   // Serial output pin.
   output reg        sdo_o,
   output reg        sdo_oe_o,
   // Device state inputs.
   input  wire       reset_output_i,
   input  wire       init_mode_i,
   input  wire       wake_status_pend_i,
   input  wire       timer_running_i,
   input  wire [7:0] tx_byte_i,
   // Command results.
   output reg        cmd_valid_o,
   output reg  [6:0] cmd_addr_o,
   output reg  [7:0] cmd_data_o,
   output reg        cmd_write_o,
   output reg  [1:0] mode_o,
   output reg        restart_o,
   output reg        int_pulse_o,
   output reg        cmd_fault_o,
   output reg        frame_err_o
);

   // ---------------------------------------------------------------------
   // Pin synchronisation
   // ---------------------------------------------------------------------
   wire [3:0] pins_s;   // Synchronised csn, sclk, sdi and reset output.
   wire       csn_s  = pins_s[3];
   wire       sclk_s = pins_s[2];
   wire       sdi_s  = pins_s[1];
   wire       ro_s   = pins_s[0];

   // Reset levels match idle pins, so reset
   // is never followed by a false select edge.
   sbcspi_sync #(
      .W (4)
   ) u_sync (
      .mclk_i    (mclk_i),
      .rst_n_i   (rst_n_i),
      .async_i   ({csn_i, sclk_i, sdi_i, reset_output_i}),
      .rst_val_i (4'b1001),
      .sync_o    (pins_s)
   );

   // ---------------------------------------------------------------------
   // State
   // ---------------------------------------------------------------------
   reg        csn_d;      // Previous select level.
   reg        sclk_d;     // Previous clock level.
   reg [15:0] rx_sr;      // Input shift register.
   reg [15:0] tx_sr;      // Output shift register.
   reg [`SBCSPI_CNT_W-1:0] clk_cnt;   // Falling edges seen this frame.
   reg        edge_bad;   // Clock was high at the select falling edge.
   reg        ro_seen;    // Reset output low at some point in frame.
   reg        err_pend;   // Error to report on the next frame.
   reg        load_share; // Auxiliary regulator load-share state.
   reg [7:0]  bus_wake;   // Bus wake control copy.
   reg [7:0]  wake_src;   // Wake source control copy.

   // Edge strobes. Clock edges count only while
   // selected; clocks between frames are ignored.
   wire cs_fall  = csn_d & ~csn_s;
   wire cs_rise  = ~csn_d & csn_s;
   wire sck_fall = ~csn_s & sclk_d & ~sclk_s;
   wire sck_rise = ~csn_s & ~sclk_d & sclk_s;

   // Odd parity check helper, used for the watchdog byte.
   function sbcspi_odd;
      input [7:0] b;
      begin
         sbcspi_odd = ^b;
      end
   endfunction

   // Address class helper: true for any mapped register address.
   function sbcspi_mapped;
      input [6:0] a;
      begin
         sbcspi_mapped = (a <= `SBCSPI_ADDR_CTL_HI) ||
                         ((a >= `SBCSPI_ADDR_STAT_LO) && (a <= `SBCSPI_ADDR_STAT_HI));
      end
   endfunction

   // ---------------------------------------------------------------------
   // Command decode of the received word
   // ---------------------------------------------------------------------
   // Word fields after sixteen shifts; the
   // first bit received sits at bit 0.
   wire [6:0] w_addr  = rx_sr[`SBCSPI_ADDR_MSB:0];
   wire       w_wr    = rx_sr[`SBCSPI_WRITE_BIT];
   wire [7:0] w_data  = rx_sr[15:`SBCSPI_DATA_LSB];
   wire [1:0] w_mode  = w_data[`SBCSPI_MODE_MSB:`SBCSPI_MODE_LSB];
   wire       is_mode = w_wr && (w_addr == `SBCSPI_ADDR_MODE);
   wire       in_stop = (mode_o == `SBCSPI_MODE_STOP);
   // No wake source of any kind is enabled.
   wire       no_wake = (bus_wake == 8'h00) && (wake_src == 8'h00);
   // Measured wake inputs one or two alone.
   wire       meas_only = wake_src[`SBCSPI_MEAS_BIT] && (bus_wake == 8'h00) &&
                          ((wake_src & 8'hd8) == 8'h00) &&
                          (wake_src[`SBCSPI_WK1_BIT] | wake_src[`SBCSPI_WK2_BIT]) &&
                          !wake_src[`SBCSPI_TIMER_BIT];
   // The timer is the only wake source.
   wire       timer_only = (bus_wake == 8'h00) && (wake_src == (8'h01 << `SBCSPI_TIMER_BIT));
   // Commands Stop mode lets through. Sleep passes
   // so it reaches its own Restart branch.
   wire       stop_ok = !w_wr || (w_addr == `SBCSPI_ADDR_WDOG) ||
                        is_mode && (w_mode == `SBCSPI_MODE_NORMAL ||
                                    w_mode == `SBCSPI_MODE_SLEEP ||
                                    w_data[`SBCSPI_SOFTRST_BIT]) ||
                        (w_addr >= `SBCSPI_ADDR_STAT_LO);

   // Verdict of the checker on the word in rx_sr.
   reg        next_fault;   // Command fault raised by this word.
   reg        next_accept;  // Write is carried out.
   reg        next_restart; // Restart mode entered.
   reg        next_int;     // Interrupt pulse requested.
   reg [1:0]  next_mode;    // Mode after the command.
   reg [7:0]  next_data;    // Data as actually written.

   // Judges a complete, well-framed word against the mode state.
   always @* begin
      next_fault   = 1'b0;
      next_accept  = w_wr && sbcspi_mapped(w_addr);
      next_restart = 1'b0;
      next_int     = 1'b0;
      next_mode    = mode_o;
      next_data    = w_data;
      // Checks run in priority order; the first
      // that fires decides the write.
      if (rx_sr == 16'h0000 || rx_sr == 16'hffff) begin
         next_fault  = 1'b1;
         next_accept = 1'b0;
      end else if (!sbcspi_mapped(w_addr)) begin
         next_accept = 1'b0;
      end else if (in_stop && !stop_ok) begin
         next_fault  = 1'b1;
         next_accept = 1'b0;
      end else if (w_wr && w_addr == `SBCSPI_ADDR_WDOG && sbcspi_odd(w_data)) begin
         next_fault  = 1'b1;
         next_accept = 1'b0;
      end else if (w_wr && w_addr == `SBCSPI_ADDR_TIMER && w_data[7:4] >= w_data[3:0]) begin
         next_fault  = 1'b1;
         next_accept = 1'b0;
      end else if (is_mode) begin
         // Illegal transitions first, then plain ones.
         if (init_mode_i && (w_mode == `SBCSPI_MODE_STOP || w_mode == `SBCSPI_MODE_SLEEP)) begin
            next_fault = 1'b1;
            next_mode  = `SBCSPI_MODE_NORMAL;
         end else if (in_stop && w_mode == `SBCSPI_MODE_SLEEP) begin
            next_fault   = 1'b1;
            next_restart = 1'b1;
            next_accept  = 1'b0;
         end else if (in_stop && w_mode == `SBCSPI_MODE_NORMAL) begin
            next_mode = `SBCSPI_MODE_NORMAL;
            if (w_data[5:0] != 6'h00) begin
               next_fault = 1'b1;
               next_data  = {`SBCSPI_MODE_NORMAL, 6'h00};
            end
         end else if (w_mode == `SBCSPI_MODE_SLEEP && (no_wake || meas_only)) begin
            next_fault   = 1'b1;
            next_restart = 1'b1;                                    // rest still executed
         end else if (w_mode == `SBCSPI_MODE_SLEEP && timer_only && !timer_running_i) begin
            next_restart = 1'b1;
         end else if (w_mode == `SBCSPI_MODE_STOP) begin
            next_mode = `SBCSPI_MODE_STOP;
            next_int  = wake_status_pend_i;
         end else begin
            next_mode = w_mode;
         end
         // A soft reset always ends in Restart.
         if (w_data[`SBCSPI_SOFTRST_BIT]) begin
            next_restart = 1'b1;
         end
      end
      // Load share, once set, survives later writes.
      if (w_wr && w_addr == `SBCSPI_ADDR_SUPCTL && load_share) begin
         next_data[`SBCSPI_LOADSHARE] = 1'b1;
      end
   end

   // ---------------------------------------------------------------------
   // Frame tracking and shifting
   // ---------------------------------------------------------------------
   // Input bits are taken on falling clock edges, output bits advance on
   // rising edges; the word is acted on only at the select rising edge.
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         // Idle: select high, clock low, pad released.
         csn_d       <= 1'b1;
         sclk_d      <= 1'b0;
         rx_sr       <= 16'h0000;
         tx_sr       <= 16'h0000;
         clk_cnt     <= {`SBCSPI_CNT_W{1'b0}};
         edge_bad    <= 1'b0;
         ro_seen     <= 1'b0;
         err_pend    <= 1'b0;
         sdo_o       <= 1'b1;
         sdo_oe_o    <= 1'b0;
         cmd_valid_o <= 1'b0;
         cmd_addr_o  <= 7'h00;
         cmd_data_o  <= `SBCSPI_RST_BYTE;
         cmd_write_o <= 1'b0;
         mode_o      <= `SBCSPI_MODE_NORMAL;
         restart_o   <= 1'b0;
         int_pulse_o <= 1'b0;
         cmd_fault_o <= 1'b0;
         frame_err_o <= 1'b0;
         load_share  <= 1'b0;
         bus_wake    <= `SBCSPI_RST_BYTE;
         wake_src    <= `SBCSPI_RST_BYTE;
      end else begin
         // Edge history and one-cycle pulses; the error
         // copy trails the pending flag by a clock.
         csn_d       <= csn_s;
         sclk_d      <= sclk_s;
         cmd_valid_o <= 1'b0;
         int_pulse_o <= 1'b0;
         restart_o   <= 1'b0;
         frame_err_o <= err_pend;
         if (cs_fall) begin
            // Start of frame: error bit leads the word, before any clock.
            clk_cnt  <= {`SBCSPI_CNT_W{1'b0}};
            edge_bad <= sclk_s;
            ro_seen  <= ~ro_s;
            // Error bit, seven zeros, then the data byte.
            tx_sr    <= {err_pend, 7'h00, tx_byte_i};
            sdo_oe_o <= 1'b1;
            sdo_o    <= ro_s ? err_pend : 1'b1;
         end else if (!csn_s) begin
            // Reset output low anywhere spoils the frame.
            if (!ro_s) begin
               ro_seen <= 1'b1;
            end
            // The count saturates so it cannot wrap to 16.
            if (sck_fall) begin
               rx_sr <= {sdi_s, rx_sr[15:1]};
               if (clk_cnt != 5'h1f) begin
                  clk_cnt <= clk_cnt + 5'd1;
               end
            end
            // One bit per rising edge; a low reset
            // output forces the level high instead.
            if (sck_rise) begin
               tx_sr <= {tx_sr[14:0], 1'b0};
               sdo_o <= ro_s ? tx_sr[14] : 1'b1;
            end else if (!ro_s) begin
               sdo_o <= 1'b1;
            end
         end else if (!ro_s) begin
            // Deselected with reset output low: pad released, level forced high.
            sdo_o <= 1'b1;
         end
         // End of frame: release the pad, then judge
         // it; only a clean frame is interpreted.
         if (cs_rise) begin
            sdo_oe_o <= 1'b0;
            if (clk_cnt == `SBCSPI_FRAME_BITS && !(edge_bad | sclk_s) &&
                !(ro_seen | ~ro_s)) begin
               // Well-framed word: interpret it now.
               err_pend    <= 1'b0;
               cmd_valid_o <= 1'b1;
               cmd_addr_o  <= w_addr;
               cmd_write_o <= next_accept;
               cmd_data_o  <= next_data;
               mode_o      <= next_mode;
               restart_o   <= next_restart;
               int_pulse_o <= next_int;
               // A fault wins over a clear in one word.
               if (next_fault) begin
                  cmd_fault_o <= 1'b1;
               end else if (!w_wr && w_addr == `SBCSPI_ADDR_DEVSTAT &&
                            rx_sr[`SBCSPI_WRITE_BIT] == 1'b0) begin
                  // A plain status read leaves the flag.
                  cmd_fault_o <= cmd_fault_o;
               end
               if (w_wr && w_addr == `SBCSPI_ADDR_DEVSTAT && !next_fault &&
                   !w_data[`SBCSPI_FAULT_BIT]) begin
                  cmd_fault_o <= 1'b0;
               end
               // Local copies of the bytes the checks use.
               if (next_accept && w_addr == `SBCSPI_ADDR_SUPCTL) begin
                  load_share <= next_data[`SBCSPI_LOADSHARE];
               end
               if (next_accept && w_addr == `SBCSPI_ADDR_BUSWK) begin
                  bus_wake <= next_data;
               end
               if (next_accept && w_addr == `SBCSPI_ADDR_WKSRC) begin
                  wake_src <= next_data;
               end
               // Restart overrides the requested mode.
               if (next_restart) begin
                  mode_o <= `SBCSPI_MODE_RESET;
               end
            end else if (clk_cnt == 5'd0 && !(edge_bad | sclk_s) &&
                         !(ro_seen | ~ro_s)) begin
               err_pend <= 1'b0;                                    // poll only
            end else begin
               // Bad count, clock high at an edge, or reset.
               err_pend <= 1'b1;
            end
         end
      end
   end

endmodule

// ### bench/sbcspi_frame_checker_properties.sv
/* Concurrent checks on the ports of the serial control port frame checker.
   Assumes it is bound to sbcspi_frame_checker and sees only its ports. */
`timescale 1ns/100ps

module sbcspi_frame_checker_properties (
   // Clock and reset.
   input wire       mclk_i,
   input wire       rst_n_i,
   // Pins and device levels.
   input wire       csn_i,
   input wire       sclk_i,
   input wire       reset_output_i,
   input wire       sdo_o,
   input wire       sdo_oe_o,
   // Command results.
   input wire       cmd_valid_o,
   input wire [6:0] cmd_addr_o,
   input wire       cmd_write_o,
   input wire [1:0] mode_o,
   input wire       restart_o,
   input wire       int_pulse_o,
   input wire       cmd_fault_o,
   input wire       frame_err_o
);
   // ------------------------------------------------------------------
   // Shared clocking
   // ------------------------------------------------------------------
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   // Output released once select has settled high.
   release_out_a: assert property (csn_i [*5] |-> !sdo_oe_o)
      else $error("serial output driven while deselected");
   // Output forced high while the reset output is low.
   reset_high_a: assert property ((!reset_output_i) [*5] |-> sdo_o)
      else $error("serial output not high during reset output low");
   // Pending framing error shows before the first clock.
   err_shown_a: assert property ($fell(csn_i) && frame_err_o |-> ##[2:5] (sdo_oe_o && sdo_o))
      else $error("error bit missing at frame start");
   // A clean history gives a low error bit.
   err_clear_a: assert property ($fell(csn_i) && !frame_err_o && reset_output_i && !sclk_i
                                 |-> ##[2:5] (sdo_oe_o && !sdo_o))
      else $error("error bit high without a framing fault");
   // Output only moves after a rising serial clock.
   shift_hold_a: assert property ((!sclk_i && !csn_i && reset_output_i) [*6] |=> $stable(sdo_o))
      else $error("serial output moved while clock low");
   // A word is taken only after select is back high.
   valid_late_a: assert property (cmd_valid_o |-> $past(csn_i, 1) && $past(csn_i, 2))
      else $error("command taken while selected");
   // The fault flag clears only through a command.
   fault_keep_a: assert property ($fell(cmd_fault_o) |-> cmd_valid_o || $past(cmd_valid_o))
      else $error("fault flag cleared without a command");
   // The fault flag rises only through a command.
   fault_cause_a: assert property ($rose(cmd_fault_o) |-> cmd_valid_o || $past(cmd_valid_o))
      else $error("fault flag set without a command");
   // Interrupt is a single pulse into stop mode.
   int_stop_a: assert property (int_pulse_o |=> !int_pulse_o && mode_o == 2'h2)
      else $error("interrupt pulse wrong");
   // Restart comes with a command and the restart mode code.
   restart_mode_a: assert property (restart_o |-> cmd_valid_o && mode_o == 2'h3)
      else $error("restart without restart mode");
   // Unused addresses are never written.
   unused_addr_a: assert property (cmd_valid_o && ((cmd_addr_o > 7'h1e && cmd_addr_o < 7'h40)
                                   || cmd_addr_o == 7'h7f) |-> !cmd_write_o)
      else $error("write accepted at unused address");
endmodule

bind sbcspi_frame_checker sbcspi_frame_checker_properties u_props (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .csn_i(csn_i), .sclk_i(sclk_i),
   .reset_output_i(reset_output_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
   .cmd_valid_o(cmd_valid_o), .cmd_addr_o(cmd_addr_o), .cmd_write_o(cmd_write_o),
   .mode_o(mode_o), .restart_o(restart_o), .int_pulse_o(int_pulse_o),
   .cmd_fault_o(cmd_fault_o), .frame_err_o(frame_err_o));

// ### bench/sbcspi_host_model.sv
/* Host microcontroller model acting as serial master on the control port.
   Assumes a 125 ns serial clock, idle low, unrelated to the system clock. */
`timescale 1ns/100ps

module sbcspi_host_model (
   // Serial pins driven by the host.
   output logic csn_o,
   output logic sclk_o,
   output logic sdi_o,
   // Serial output of the device.
   input  wire  sdo_i,
   input  wire  sdo_oe_i
);
   logic idle_bit = 1'b0;                       // Toggles so a released line never repeats.
   wire  line     = sdo_oe_i ? sdo_i : idle_bit; // Level the host really sees.

   initial begin
      csn_o  = 1'b1;
      sclk_o = 1'b0;
      sdi_o  = 1'b0;
   end

   always #50 idle_bit = ~idle_bit;

   // One frame of n clocks; hi_end leaves the clock high at the select rise.
   task automatic xfer(input logic [15:0] w, input int n, input bit hi_end,
                       output logic [15:0] rx, output logic err);
      rx     = 16'h0000;
      sclk_o = 1'b0;
      csn_o  = 1'b0;
      #150 err = line;
      for (int k = 0; k < n; k++) begin
         if (k < 16) rx[k] = line;
         sclk_o = 1'b1;
         sdi_o  = w[k % 16];
         #62.5 sclk_o = 1'b0;
         #62.5;
      end
      sclk_o = hi_end;
      #40 csn_o = 1'b1;
      #40 sclk_o = 1'b0;
      sdi_o = ~sdi_o;                           // Released data does not hold its value.
      #200;
   endtask
endmodule

// ### bench/sbcspi_frame_checker_tb.sv
/* Self-checking bench for the serial control port frame checker.
   Assumes the host model file and the bound checker are compiled first. */
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end

module sbcspi_frame_checker_tb;
   logic        mclk_i = 0, rst_n_i = 0, reset_output_i = 1;
   logic        init_mode_i = 0, wake_status_pend_i = 0, timer_running_i = 0;
   logic [7:0]  tx_byte_i = 8'h96;              // Bit-reversed this reads 8'h69.
   wire         csn_i, sclk_i, sdi_i, sdo_o, sdo_oe_o, cmd_valid_o, cmd_write_o;
   wire         restart_o, int_pulse_o, cmd_fault_o, frame_err_o;
   wire [6:0]   cmd_addr_o;
   wire [7:0]   cmd_data_o;
   wire [1:0]   mode_o;
   logic [15:0] rx;
   logic        err, seen_v = 0, seen_r = 0, seen_i = 0;
   int          n_fail = 0, tests_run = 0, cycles = 0;

   sbcspi_frame_checker u_sbcspi_frame_checker (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .csn_i(csn_i), .sclk_i(sclk_i), .sdi_i(sdi_i),
      .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .reset_output_i(reset_output_i),
      .init_mode_i(init_mode_i), .wake_status_pend_i(wake_status_pend_i),
      .timer_running_i(timer_running_i), .tx_byte_i(tx_byte_i), .cmd_valid_o(cmd_valid_o),
      .cmd_addr_o(cmd_addr_o), .cmd_data_o(cmd_data_o), .cmd_write_o(cmd_write_o),
      .mode_o(mode_o), .restart_o(restart_o), .int_pulse_o(int_pulse_o),
      .cmd_fault_o(cmd_fault_o), .frame_err_o(frame_err_o));

   sbcspi_host_model u_host (.csn_o(csn_i), .sclk_o(sclk_i), .sdi_o(sdi_i),
      .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o));

   initial begin
      forever #5 mclk_i = ~mclk_i;
   end

   // Catch one-cycle pulses and cut a hang short.
   always @(posedge mclk_i) begin
      if (cmd_valid_o === 1'b1) seen_v <= 1'b1;
      if (restart_o === 1'b1) seen_r <= 1'b1;
      if (int_pulse_o === 1'b1) seen_i <= 1'b1;
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_fail++;
         complete_run();
      end
   end

   // Reset for 8 cycles with the given device levels.
   task rst(input logic i, input logic p, input logic t);
      @(posedge mclk_i) #1 rst_n_i = 0;
      init_mode_i = i;
      wake_status_pend_i = p;
      timer_running_i = t;
      repeat (8) @(posedge mclk_i);
      #1 rst_n_i = 1;
      repeat (4) @(posedge mclk_i);
      #1;
   endtask

   // Full frame, then check response, valid strobe, fault, mode and restart.
   task cmd(input [15:0] w, input ev, input ef, input [1:0] em, input er);
      seen_v = 0;
      seen_r = 0;
      u_host.xfer(w, 16, 0, rx, err);
      `CHK(rx[15:1], {8'h69, 7'h00})
      `CHK(seen_v, ev)
      `CHK(cmd_fault_o, ef)
      `CHK(mode_o, em)
      `CHK(seen_r, er)
   endtask

   task done(input string name);
      $display("test %s ended, %0d mismatches so far", name, n_fail);
   endtask

   task complete_run();
      $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      rst(0, 0, 0);
      `CHK({sdo_o, sdo_oe_o, mode_o, cmd_fault_o, frame_err_o}, 6'h20)
      cmd(16'h0081, 1, 0, 2'h0, 0);
      `CHK({cmd_write_o, cmd_addr_o, cmd_data_o}, 16'h8100)
      done("basic");
      for (int s = 0; s < 3; s++) begin
         rst(0, 0, 0);
         seen_v = 0;
         u_host.xfer(16'h0081, (s == 1) ? 17 : (s == 0) ? 15 : 16, s == 2, rx, err);
         `CHK({seen_v, frame_err_o}, 2'h1)
         u_host.xfer(16'h0000, 0, 0, rx, err);
         `CHK(err, 1'b1)
         u_host.xfer(16'h0000, 0, 0, rx, err);
         `CHK(err, 1'b0)
      end
      done("framing");
      rst(0, 0, 0);
      seen_v = 0;
      fork
         u_host.xfer(16'h0081, 16, 0, rx, err);
         begin
            repeat (40) @(posedge mclk_i);
            #1 reset_output_i = 0;
            repeat (20) @(posedge mclk_i);
            #1 `CHK(sdo_o, 1'b1)
            reset_output_i = 1;
         end
      join
      `CHK(seen_v, 1'b0)
      u_host.xfer(16'h0000, 0, 0, rx, err);
      `CHK(err, 1'b1)
      done("reset output");
      rst(0, 0, 0);
      cmd(16'h0000, 1, 1, 2'h0, 0);
      cmd(16'h00c3, 1, 0, 2'h0, 0);
      cmd(16'hffff, 1, 1, 2'h0, 0);
      done("stuck input");
      rst(0, 1, 0);
      seen_i = 0;
      cmd(16'h8081, 1, 0, 2'h2, 0);
      `CHK(seen_i, 1'b1)
      cmd(16'h4081, 1, 1, 2'h3, 1);
      done("stop to sleep");
      rst(0, 0, 0);
      cmd(16'h8081, 1, 0, 2'h2, 0);
      cmd(16'h138c, 1, 1, 2'h2, 0);
      cmd(16'h00c3, 1, 0, 2'h2, 0);
      cmd(16'h0181, 1, 1, 2'h0, 0);
      `CHK(cmd_data_o, 8'h00)
      done("stop mode");
      rst(1, 0, 0);
      cmd(16'h8081, 1, 1, 2'h0, 0);
      rst(0, 0, 0);
      cmd(16'h4081, 1, 1, 2'h3, 1);
      `CHK(cmd_write_o, 1'b1)
      rst(0, 0, 0);
      cmd(16'h2186, 1, 0, 2'h0, 0);
      cmd(16'h4081, 1, 1, 2'h3, 1);
      rst(0, 0, 0);
      cmd(16'h0486, 1, 0, 2'h0, 0);
      cmd(16'h4081, 1, 0, 2'h3, 1);
      rst(0, 0, 1);
      cmd(16'h0486, 1, 0, 2'h0, 0);
      cmd(16'h4081, 1, 0, 2'h1, 0);
      done("sleep entry");
      rst(0, 0, 0);
      cmd(16'h0383, 1, 0, 2'h0, 0);
      cmd(16'h0183, 1, 1, 2'h0, 0);
      rst(0, 0, 0);
      cmd(16'h138c, 1, 0, 2'h0, 0);
      cmd(16'h338c, 1, 1, 2'h0, 0);
      rst(0, 0, 0);
      cmd(16'h088a, 1, 0, 2'h0, 0);
      cmd(16'h008a, 1, 0, 2'h0, 0);
      `CHK(cmd_data_o[3], 1'b1)
      cmd(16'h55a0, 1, 0, 2'h0, 0);
      `CHK(cmd_write_o, 1'b0)
      done("settings");
      complete_run();
   end
endmodule
